/* File: src/bus_port_map.svh */
// Register offsets, field positions, reset values and widths for the
// shared port block. Assumes a plain address/strobe register port.
`ifndef BUS_PORT_MAP_SVH
`define BUS_PORT_MAP_SVH

`define ADDR_PORT_F_DIRECTION 4'h0
`define ADDR_PORT_F_PINS 4'h1
`define ADDR_PORT_F_OUTPUT_LATCH 4'h2
`define ADDR_ANALOG_PIN_CONFIG 4'h3
`define ADDR_MEMORY_BUS_CONTROL 4'h4
`define ADDR_PORT_G_DIRECTION 4'h5
`define ADDR_PORT_G_PINS 4'h6
`define ADDR_PORT_G_OUTPUT_LATCH 4'h7
`define ADDR_CHIP_SELECT_TWO_RANGE 4'h8
`define ADDR_IO_SELECT_RANGE 4'h9

`define RESET_PORT_F_DIRECTION 8'hFF
`define RESET_PORT_F_OUTPUT_LATCH 8'h00
`define RESET_ANALOG_PIN_CONFIG 8'h00
`define RESET_MEMORY_BUS_CONTROL 8'h00
`define RESET_PORT_G_DIRECTION 5'h1F
`define RESET_PORT_G_OUTPUT_LATCH 5'h00
`define RESET_RANGE 8'h00

// Writable bit masks of the mixed-access registers
`define MASK_ANALOG_PIN_CONFIG 8'h3F
`define MASK_MEMORY_BUS_CONTROL 8'hF3

// Field positions in memory_bus_control
`define EXTERNAL_BUS_DISABLE_BIT 7
`define PROGRAM_MEMORY_MODE_BIT 6
`define BUS_WIDTH_MODE_HIGH 1
`define BUS_WIDTH_MODE_LOW 0
`define BUS_WIDTH_SIXTEEN 2'h1
`define BUS_WAIT_HIGH_BIT 5
`define BUS_WAIT_LOW_BIT 4

// Field position in analog_pin_config
`define ANALOG_PIN_SELECT_BIT 0

`endif

/* File: src/bus_port_pkg.sv */
// Types shared by the shared port block.
// Assumes the map header supplies all numbers.
package bus_port_pkg;
	typedef enum logic {
		variant_small_type_v,
		variant_large_type_v
	} variant_type;
	typedef logic [7:0] byte_type;
endpackage

/* File: src/bus_shared_port.sv */
// Function
// - Second port has five pins with direction, latch and pin read each.
// - Direction bit 1 releases the driver; the pin is an input.
// - Direction bit 0 drives the pin from its output latch.
// - Latch reads return the stored outputs, not pin levels.
// - Second port bits 0-4: address latch, read, low write, high write, byte.
// - External 8-bit execution frees the high write pin as a port pin.
// - Second port is I/O only with bus disabled and internal execution.
// - After reset the second port pins carry bus control functions, the high write pin only with internal execution.
// - First port bits 0-2 are port pins or analog channels.
// - First port bit 3 is port pin or I/O-space chip select.
// - First port bit 4 is port pin, second select, or address bit 16.
// - First port bit 5 is port pin or first chip select.
// - First port bit 6 is port pin or low byte select.
// - First port bit 7 is port pin or high byte select.
// - Byte selects are port pins unless bus width mode is 01.
// - Chip selects are port pins only with their range registers zero.
// - Analog configuration picks analog or digital, analog after reset.
//
// Top of the two shared ports. Assumes the bus controller supplies
// strobe levels and drive enables, and the core reports execution source.
`timescale 1ns/10ps
`default_nettype none
`include "bus_port_map.svh"
module bus_shared_port #(
	parameter bus_port_pkg::variant_type VARIANT =
		bus_port_pkg::variant_large_type_v
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [3:0] i_address,
	input wire logic [7:0] i_write_data,
	input wire logic i_write,
	input wire logic i_read,
	output logic [7:0] o_read_data,
	input wire logic i_internal_execution,
	input wire logic i_address_latch_strobe,
	input wire logic i_read_strobe,
	input wire logic i_write_strobe_low,
	input wire logic i_write_strobe_high,
	input wire logic i_byte_address_bit,
	input wire logic i_bus_control_drive,
	input wire logic i_io_space_select,
	input wire logic i_chip_select_one,
	input wire logic i_chip_select_two,
	input wire logic i_address_bit_sixteen,
	input wire logic i_low_byte_strobe,
	input wire logic i_high_byte_strobe,
	input wire logic [7:0] i_port_f_pin,
	output logic [7:0] o_port_f_pin,
	output logic [7:0] o_port_f_pin_oe,
	output logic [2:0] o_analog_pin_enable,
	input wire logic [4:0] i_port_g_pin,
	output logic [4:0] o_port_g_pin,
	output logic [4:0] o_port_g_pin_oe,
	output logic o_external_bus_disable,
	output logic o_program_memory_mode_bit,
	output logic [1:0] o_bus_wait,
	output logic [1:0] o_bus_width_mode
);
	logic [7:0] port_f_direction;
	logic [7:0] port_f_output_latch;
	logic [7:0] analog_pin_config;
	logic [7:0] memory_bus_control;
	logic [4:0] port_g_direction;
	logic [4:0] port_g_output_latch;
	logic [7:0] chip_select_two_range;
	logic [7:0] io_select_range;
	logic [7:0] port_f_sync;
	logic [4:0] port_g_sync;
	logic [7:0] next_read_data;

	// Address decode of the register port
	wire hit_f_dir = i_address == `ADDR_PORT_F_DIRECTION;
	wire hit_f_pins = i_address == `ADDR_PORT_F_PINS;
	wire hit_f_lat = i_address == `ADDR_PORT_F_OUTPUT_LATCH;
	wire hit_analog = i_address == `ADDR_ANALOG_PIN_CONFIG;
	wire hit_mem = i_address == `ADDR_MEMORY_BUS_CONTROL;
	wire hit_g_dir = i_address == `ADDR_PORT_G_DIRECTION;
	wire hit_g_pins = i_address == `ADDR_PORT_G_PINS;
	wire hit_g_lat = i_address == `ADDR_PORT_G_OUTPUT_LATCH;
	wire hit_cs2 = i_address == `ADDR_CHIP_SELECT_TWO_RANGE;
	wire hit_io = i_address == `ADDR_IO_SELECT_RANGE;

	// Pin inputs come from outside the clock domain
	pin_sync #(.WIDTH(8)) sync_f (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_async(i_port_f_pin),
		.o_sync(port_f_sync)
	);
	pin_sync #(.WIDTH(5)) sync_g (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_async(i_port_g_pin),
		.o_sync(port_g_sync)
	);

	// Mode decode
	wire bus_disabled = memory_bus_control[`EXTERNAL_BUS_DISABLE_BIT];
	wire [1:0] width_mode = memory_bus_control[`BUS_WIDTH_MODE_HIGH:
		`BUS_WIDTH_MODE_LOW];
	wire sixteen_bit = width_mode == `BUS_WIDTH_SIXTEEN;
	// Port pins only when the bus is off and code runs from inside
	wire g_is_io = bus_disabled & i_internal_execution;
	wire g_high_write_free = ~i_internal_execution & ~sixteen_bit;
	wire io_range_zero = io_select_range == 8'h00;
	wire cs2_range_zero = chip_select_two_range == 8'h00;
	// Selects need every relevant range cleared to become port pins
	wire selects_zero = (VARIANT == bus_port_pkg::variant_large_type_v) ?
		(io_range_zero & cs2_range_zero) : io_range_zero;
	// Address bit 16 on the small variant frees like the second port
	wire bit4_bus = (VARIANT == bus_port_pkg::variant_large_type_v) ?
		~selects_zero : ~g_is_io;
	// Analog pins follow the select bit; cleared means analog
	wire digital_pins = analog_pin_config[`ANALOG_PIN_SELECT_BIT];
	wire bit4_level = (VARIANT == bus_port_pkg::variant_large_type_v) ?
		i_chip_select_two : i_address_bit_sixteen;

	// Which bus function owns each first port pin
	wire [7:0] f_bus_owns = {sixteen_bit, sixteen_bit, ~selects_zero,
		bit4_bus, ~selects_zero, 3'h0};
	wire [7:0] f_bus_level = {i_high_byte_strobe, i_low_byte_strobe,
		i_chip_select_one, bit4_level, i_io_space_select, 3'h0};
	wire [4:0] g_bus_level = {i_byte_address_bit, i_write_strobe_high,
		i_write_strobe_low, i_read_strobe, i_address_latch_strobe};
	wire [4:0] g_bus_owns = g_is_io ? 5'h00 :
		{1'b1, ~g_high_write_free, 3'h7};

	// Analog channels hold their drivers off and read as zero
	assign o_analog_pin_enable = {3{~digital_pins}};

	// Analog channels keep the driver off whatever the direction bit says
	wire [7:0] f_direction_eff = port_f_direction |
		{5'h00, {3{~digital_pins}}};

	// Port F bit 0: port pin or analog channel five
	pin_mux mux_f0 (
		.i_bus_owns(f_bus_owns[0]),
		.i_bus_level(f_bus_level[0]),
		.i_bus_drive(1'h1),
		.i_direction(f_direction_eff[0]),
		.i_latch(port_f_output_latch[0]),
		.o_out(o_port_f_pin[0]),
		.o_oe(o_port_f_pin_oe[0])
	);

	// Port F bit 1: port pin or analog channel six
	pin_mux mux_f1 (
		.i_bus_owns(f_bus_owns[1]),
		.i_bus_level(f_bus_level[1]),
		.i_bus_drive(1'h1),
		.i_direction(f_direction_eff[1]),
		.i_latch(port_f_output_latch[1]),
		.o_out(o_port_f_pin[1]),
		.o_oe(o_port_f_pin_oe[1])
	);

	// Port F bit 2: port pin or analog channel seven
	pin_mux mux_f2 (
		.i_bus_owns(f_bus_owns[2]),
		.i_bus_level(f_bus_level[2]),
		.i_bus_drive(1'h1),
		.i_direction(f_direction_eff[2]),
		.i_latch(port_f_output_latch[2]),
		.o_out(o_port_f_pin[2]),
		.o_oe(o_port_f_pin_oe[2])
	);

	// Port F bit 3: port pin or I/O-space select
	pin_mux mux_f3 (
		.i_bus_owns(f_bus_owns[3]),
		.i_bus_level(f_bus_level[3]),
		.i_bus_drive(1'h1),
		.i_direction(f_direction_eff[3]),
		.i_latch(port_f_output_latch[3]),
		.o_out(o_port_f_pin[3]),
		.o_oe(o_port_f_pin_oe[3])
	);

	// Port F bit 4: second select or address bit 16, by variant
	pin_mux mux_f4 (
		.i_bus_owns(f_bus_owns[4]),
		.i_bus_level(f_bus_level[4]),
		.i_bus_drive(1'h1),
		.i_direction(f_direction_eff[4]),
		.i_latch(port_f_output_latch[4]),
		.o_out(o_port_f_pin[4]),
		.o_oe(o_port_f_pin_oe[4])
	);

	// Port F bit 5: port pin or first chip select
	pin_mux mux_f5 (
		.i_bus_owns(f_bus_owns[5]),
		.i_bus_level(f_bus_level[5]),
		.i_bus_drive(1'h1),
		.i_direction(f_direction_eff[5]),
		.i_latch(port_f_output_latch[5]),
		.o_out(o_port_f_pin[5]),
		.o_oe(o_port_f_pin_oe[5])
	);

	// Port F bit 6: port pin or low byte strobe
	pin_mux mux_f6 (
		.i_bus_owns(f_bus_owns[6]),
		.i_bus_level(f_bus_level[6]),
		.i_bus_drive(1'h1),
		.i_direction(f_direction_eff[6]),
		.i_latch(port_f_output_latch[6]),
		.o_out(o_port_f_pin[6]),
		.o_oe(o_port_f_pin_oe[6])
	);

	// Port F bit 7: port pin or high byte strobe
	pin_mux mux_f7 (
		.i_bus_owns(f_bus_owns[7]),
		.i_bus_level(f_bus_level[7]),
		.i_bus_drive(1'h1),
		.i_direction(f_direction_eff[7]),
		.i_latch(port_f_output_latch[7]),
		.o_out(o_port_f_pin[7]),
		.o_oe(o_port_f_pin_oe[7])
	);

	// Port G bit 0: address latch strobe
	pin_mux mux_g0 (
		.i_bus_owns(g_bus_owns[0]),
		.i_bus_level(g_bus_level[0]),
		.i_bus_drive(i_bus_control_drive),
		.i_direction(port_g_direction[0]),
		.i_latch(port_g_output_latch[0]),
		.o_out(o_port_g_pin[0]),
		.o_oe(o_port_g_pin_oe[0])
	);

	// Port G bit 1: read strobe
	pin_mux mux_g1 (
		.i_bus_owns(g_bus_owns[1]),
		.i_bus_level(g_bus_level[1]),
		.i_bus_drive(i_bus_control_drive),
		.i_direction(port_g_direction[1]),
		.i_latch(port_g_output_latch[1]),
		.o_out(o_port_g_pin[1]),
		.o_oe(o_port_g_pin_oe[1])
	);

	// Port G bit 2: low write strobe
	pin_mux mux_g2 (
		.i_bus_owns(g_bus_owns[2]),
		.i_bus_level(g_bus_level[2]),
		.i_bus_drive(i_bus_control_drive),
		.i_direction(port_g_direction[2]),
		.i_latch(port_g_output_latch[2]),
		.o_out(o_port_g_pin[2]),
		.o_oe(o_port_g_pin_oe[2])
	);

	// Port G bit 3: high write strobe, a port pin in 8-bit fetch
	pin_mux mux_g3 (
		.i_bus_owns(g_bus_owns[3]),
		.i_bus_level(g_bus_level[3]),
		.i_bus_drive(i_bus_control_drive),
		.i_direction(port_g_direction[3]),
		.i_latch(port_g_output_latch[3]),
		.o_out(o_port_g_pin[3]),
		.o_oe(o_port_g_pin_oe[3])
	);

	// Port G bit 4: byte address bit
	pin_mux mux_g4 (
		.i_bus_owns(g_bus_owns[4]),
		.i_bus_level(g_bus_level[4]),
		.i_bus_drive(i_bus_control_drive),
		.i_direction(port_g_direction[4]),
		.i_latch(port_g_output_latch[4]),
		.o_out(o_port_g_pin[4]),
		.o_oe(o_port_g_pin_oe[4])
	);

	wire [7:0] f_pin_read = digital_pins ? port_f_sync :
		{port_f_sync[7:3], 3'h0};

	// Read mux; latch registers return stored values, not pins
	always_comb begin
		next_read_data = 8'h00;
		case (i_address)
			`ADDR_PORT_F_DIRECTION: next_read_data = port_f_direction;
			`ADDR_PORT_F_PINS: next_read_data = f_pin_read;
			`ADDR_PORT_F_OUTPUT_LATCH: next_read_data = port_f_output_latch;
			`ADDR_ANALOG_PIN_CONFIG: next_read_data = analog_pin_config;
			`ADDR_MEMORY_BUS_CONTROL: next_read_data = memory_bus_control;
			`ADDR_PORT_G_DIRECTION: next_read_data = {3'h0, port_g_direction};
			`ADDR_PORT_G_PINS: next_read_data = {3'h0, port_g_sync};
			`ADDR_PORT_G_OUTPUT_LATCH:
				next_read_data = {3'h0, port_g_output_latch};
			`ADDR_CHIP_SELECT_TWO_RANGE: next_read_data = chip_select_two_range;
			`ADDR_IO_SELECT_RANGE: next_read_data = io_select_range;
			default: next_read_data = 8'h00;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (i_reset)
			o_read_data <= 8'h00;
		else
			o_read_data <= i_read ? next_read_data : 8'h00;
	end

	// First port registers; a pins write lands in the latch
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			port_f_direction <= `RESET_PORT_F_DIRECTION;
			port_f_output_latch <= `RESET_PORT_F_OUTPUT_LATCH;
			analog_pin_config <= `RESET_ANALOG_PIN_CONFIG;
		end else if (i_write) begin
			if (hit_f_dir)
				port_f_direction <= i_write_data;
			if (hit_f_pins | hit_f_lat)
				port_f_output_latch <= i_write_data;
			if (hit_analog)
				analog_pin_config <= i_write_data & `MASK_ANALOG_PIN_CONFIG;
		end
	end

	// Second port and bus configuration; reset leaves the bus in charge
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			memory_bus_control <= `RESET_MEMORY_BUS_CONTROL;
			port_g_direction <= `RESET_PORT_G_DIRECTION;
			port_g_output_latch <= `RESET_PORT_G_OUTPUT_LATCH;
			chip_select_two_range <= `RESET_RANGE;
			io_select_range <= `RESET_RANGE;
		end else if (i_write) begin
			if (hit_mem)
				memory_bus_control <= i_write_data & `MASK_MEMORY_BUS_CONTROL;
			if (hit_g_dir)
				port_g_direction <= i_write_data[4:0];
			if (hit_g_pins | hit_g_lat)
				port_g_output_latch <= i_write_data[4:0];
			if (hit_cs2)
				chip_select_two_range <= i_write_data;
			if (hit_io)
				io_select_range <= i_write_data;
		end
	end

	// Bus settings handed to the bus controller
	assign o_external_bus_disable = bus_disabled;
	assign o_program_memory_mode_bit =
		memory_bus_control[`PROGRAM_MEMORY_MODE_BIT];
	assign o_bus_wait =
		memory_bus_control[`BUS_WAIT_HIGH_BIT:`BUS_WAIT_LOW_BIT];
	assign o_bus_width_mode = width_mode;
endmodule
`default_nettype wire

/* File: src/pin_mux.sv */
// One shared pin: port function or bus function.
// Assumes the caller decides which function owns the pin.
`timescale 1ns/10ps
`default_nettype none
module pin_mux (
	input wire logic i_bus_owns,
	input wire logic i_bus_level,
	input wire logic i_bus_drive,
	input wire logic i_direction,
	input wire logic i_latch,
	output logic o_out,
	output logic o_oe
);
	// Bus logic overrides direction and latch while it owns the pin
	assign o_out = i_bus_owns ? i_bus_level : i_latch;
	assign o_oe = i_bus_owns ? i_bus_drive : ~i_direction;
endmodule
`default_nettype wire

/* File: src/pin_sync.sv */
// Two-flip-flop synchroniser for a group of pin inputs.
// Assumes pins are asynchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage_one;

	// First stage feeds only the second stage
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			stage_one <= '0;
			o_sync <= '0;
		end else begin
			stage_one <= i_async;
			o_sync <= stage_one;
		end
	end
endmodule
`default_nettype wire

/* File: tb/bus_shared_port_props.sv */
// Checker for the shared port block, watching top-level ports only.
// Assumes a bind from the bench top and the single core clock.
`timescale 1ns/10ps
`default_nettype none
module bus_shared_port_props (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [3:0] i_address,
	input wire logic [7:0] i_write_data,
	input wire logic i_write,
	input wire logic i_read,
	input wire logic [7:0] o_read_data,
	input wire logic i_internal_execution,
	input wire logic i_bus_control_drive,
	input wire logic [4:0] o_port_g_pin_oe,
	input wire logic [7:0] o_port_f_pin_oe,
	input wire logic [2:0] o_analog_pin_enable,
	input wire logic o_external_bus_disable,
	input wire logic [1:0] o_bus_width_mode
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// Write data fields, named so that $past sees a plain signal
	wire logic [1:0] wd_mode = i_write_data[1:0];
	wire logic wd_disable = i_write_data[7];
	wire logic wd_digital = i_write_data[0];
	wire logic bus_keeps_g = !(o_external_bus_disable && i_internal_execution);
	sequence s_ctrl_write;
		i_write && i_address == 4'h4;
	endsequence
	sequence s_analog_write;
		i_write && i_address == 4'h3;
	endsequence
	a_read_idle_zero: assert property (!i_read |=> o_read_data == 8'h00)
		else $error("read data not zero outside a read answer");
	a_g_bus_enable: assert property (bus_keeps_g |->
		{o_port_g_pin_oe[4], o_port_g_pin_oe[2:0]} == {4{i_bus_control_drive}})
		else $error("port g bus pins do not follow bus drive");
	a_wrh_sixteen: assert property (bus_keeps_g &&
		o_bus_width_mode == 2'h1 |-> o_port_g_pin_oe[3] == i_bus_control_drive)
		else $error("high write pin not bus owned in 16-bit mode");
	a_ctrl_write_lands: assert property (s_ctrl_write |=>
		o_bus_width_mode == $past(wd_mode) &&
		o_external_bus_disable == $past(wd_disable))
		else $error("bus control write did not land");
	a_analog_write_lands: assert property (s_analog_write |=>
		o_analog_pin_enable == {3{!$past(wd_digital)}})
		else $error("analog select write did not land");
	a_analog_float: assert property (
		(o_analog_pin_enable & o_port_f_pin_oe[2:0]) == 3'h0)
		else $error("analog pin driven");
	a_byte_sel_owned: assert property (
		o_bus_width_mode == 2'h1 |-> o_port_f_pin_oe[7:6] == 2'h3)
		else $error("byte selects not driven in 16-bit mode");
	a_reset_defaults: assert property (disable iff (1'b0)
		i_reset |=> o_bus_width_mode == 2'h0 && !o_external_bus_disable &&
		o_analog_pin_enable == 3'h7 && o_read_data == 8'h00)
		else $error("reset defaults wrong");
endmodule
`default_nettype wire

/* File: tb/pin_partner.sv */
// External memory side of the shared pins: resolves each wire.
// Assumes one enable per pin, high while the chip drives.
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
	input wire logic [12:0] i_out,
	input wire logic [12:0] i_oe,
	input wire logic [12:0] i_level,
	output logic [12:0] o_wire
);
	// Chip wins where enabled, else the far device drives its level
	assign o_wire = (i_oe & i_out) | (~i_oe & i_level);
endmodule
`default_nettype wire

/* File: tb/tb_bus_shared_port.sv */
// Bench for the shared port block: register tasks and pin checks.
// Assumes the partner model resolves every pin wire.
`timescale 1ns/10ps
`default_nettype none
module tb_bus_shared_port;
	logic i_clk = 1'b0, i_reset = 1'b1, i_write = 1'b0, i_read = 1'b0;
	logic [3:0] i_address = 4'h0;
	logic [7:0] i_write_data = 8'h00, o_read_data, o_port_f_pin;
	logic [7:0] o_port_f_pin_oe;
	logic [4:0] o_port_g_pin, o_port_g_pin_oe;
	logic [2:0] o_analog_pin_enable;
	logic [1:0] o_bus_wait, o_bus_width_mode;
	logic o_external_bus_disable, o_program_memory_mode_bit;
	logic [7:0] small_f_pin, small_f_pin_oe;
	logic i_internal_execution = 1'b0, i_bus_control_drive = 1'b1;
	// Distinct strobe levels so a swapped pin shows up
	logic i_address_latch_strobe = 1'b1, i_read_strobe = 1'b0;
	logic i_write_strobe_low = 1'b1, i_write_strobe_high = 1'b1;
	logic i_byte_address_bit = 1'b0, i_io_space_select = 1'b0;
	logic i_chip_select_one = 1'b1, i_chip_select_two = 1'b0;
	logic i_address_bit_sixteen = 1'b1, i_low_byte_strobe = 1'b0;
	logic i_high_byte_strobe = 1'b1;
	wire logic [12:0] pin_wire;
	int err_count = 0, comparisons = 0;
	logic [7:0] reset_val [10] = '{8'hFF, 8'h38, 8'h00, 8'h00, 8'h00,
		8'h1F, 8'h0D, 8'h00, 8'h00, 8'h00};
	bus_shared_port bus_shared_port_i (.i_clk, .i_reset, .i_address,
		.i_write_data, .i_write, .i_read, .o_read_data, .i_internal_execution,
		.i_address_latch_strobe, .i_read_strobe, .i_write_strobe_low,
		.i_write_strobe_high, .i_byte_address_bit, .i_bus_control_drive,
		.i_io_space_select, .i_chip_select_one, .i_chip_select_two,
		.i_address_bit_sixteen, .i_low_byte_strobe, .i_high_byte_strobe,
		.i_port_f_pin(pin_wire[7:0]), .o_port_f_pin, .o_port_f_pin_oe,
		.o_analog_pin_enable, .i_port_g_pin(pin_wire[12:8]), .o_port_g_pin,
		.o_port_g_pin_oe, .o_external_bus_disable, .o_program_memory_mode_bit,
		.o_bus_wait, .o_bus_width_mode);
	pin_partner pin_partner_i (.i_out({o_port_g_pin, o_port_f_pin}),
		.i_oe({o_port_g_pin_oe, o_port_f_pin_oe}), .i_level(13'h0A3C),
		.o_wire(pin_wire));
	// Small variant shares every input; only its first port pins are checked
	bus_shared_port #(.VARIANT(bus_port_pkg::variant_small_type_v))
		bus_shared_port_small_i (.i_clk, .i_reset, .i_address,
		.i_write_data, .i_write, .i_read, .o_read_data(),
		.i_internal_execution, .i_address_latch_strobe, .i_read_strobe,
		.i_write_strobe_low, .i_write_strobe_high, .i_byte_address_bit,
		.i_bus_control_drive, .i_io_space_select, .i_chip_select_one,
		.i_chip_select_two, .i_address_bit_sixteen, .i_low_byte_strobe,
		.i_high_byte_strobe, .i_port_f_pin(pin_wire[7:0]),
		.o_port_f_pin(small_f_pin), .o_port_f_pin_oe(small_f_pin_oe),
		.o_analog_pin_enable(), .i_port_g_pin(pin_wire[12:8]),
		.o_port_g_pin(), .o_port_g_pin_oe(), .o_external_bus_disable(),
		.o_program_memory_mode_bit(), .o_bus_wait(), .o_bus_width_mode());
	initial forever #2.5 i_clk = ~i_clk;
	task automatic end_sim();
		if (err_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Register write: one strobe cycle, result visible after the edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_write <= 1'b1;
		i_address <= a;
		i_write_data <= d;
		@(posedge i_clk);
		i_write <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_read <= 1'b1;
		i_address <= a;
		@(posedge i_clk);
		i_read <= 1'b0;
		#1;
		chk("read data", exp, o_read_data);
	endtask
	// Whole run is under a hundred cycles; this cuts a hang short
	initial begin
		#5000;
		err_count++;
		end_sim();
	end
	initial begin
		repeat (2) @(posedge i_clk);
		i_reset <= 1'b0;
		#1;
		chk("g oe", 8'h17, {3'h0, o_port_g_pin_oe});
		chk("f oe", 8'h00, o_port_f_pin_oe);
		chk("analog en", 8'h07, {5'h00, o_analog_pin_enable});
		chk("small f oe", 8'h10, small_f_pin_oe);
		chk("small f level", 8'h10, small_f_pin);
		foreach (reset_val[k]) rd(k[3:0], reset_val[k]);
		wr(4'h4, 8'h01);
		chk("g oe", 8'h1F, {3'h0, o_port_g_pin_oe});
		chk("g level", 8'h0D, {3'h0, o_port_g_pin});
		chk("f byte oe", 8'hC0, {o_port_f_pin_oe[7:6], 6'h00});
		chk("f byte level", 8'h80, {o_port_f_pin[7:6], 6'h00});
		// Bus owned second port pins follow the bus drive enable, not the direction bits
		@(posedge i_clk) i_bus_control_drive <= 1'b0;
		#1 chk("g oe undriven", 8'h00, {3'h0, o_port_g_pin_oe});
		@(posedge i_clk) i_bus_control_drive <= 1'b1;
		wr(4'h4, 8'h02);
		chk("f byte oe", 8'h00, {o_port_f_pin_oe[7:6], 6'h00});
		// Reserved bits and an unmapped index
		wr(4'h3, 8'hFF);
		rd(4'h3, 8'h3F);
		chk("analog en", 8'h00, {5'h00, o_analog_pin_enable});
		wr(4'h4, 8'hFF);
		rd(4'h4, 8'hF3);
		chk("bus fields", 8'hF3, {o_external_bus_disable,
			o_program_memory_mode_bit, o_bus_wait, 2'h0, o_bus_width_mode});
		wr(4'hF, 8'hAA);
		rd(4'hF, 8'h00);
		@(posedge i_clk) i_internal_execution <= 1'b1;
		wr(4'h5, 8'h00);
		wr(4'h7, 8'h15);
		chk("g oe", 8'h1F, {3'h0, o_port_g_pin_oe});
		chk("g level", 8'h15, {3'h0, o_port_g_pin});
		chk("small f oe", 8'h00, small_f_pin_oe);
		wr(4'h5, 8'h1F);
		chk("g oe", 8'h00, {3'h0, o_port_g_pin_oe});
		repeat (4) @(posedge i_clk);
		rd(4'h6, 8'h0A);
		rd(4'h7, 8'h15);
		@(posedge i_clk) i_internal_execution <= 1'b0;
		@(posedge i_clk) #1;
		chk("g oe", 8'h17, {3'h0, o_port_g_pin_oe});
		chk("small f oe", 8'h10, small_f_pin_oe);
		// Select pins set as inputs so a bus takeover shows on the enables
		wr(4'h0, 8'h38);
		wr(4'h2, 8'h5A);
		chk("f oe", 8'hC7, o_port_f_pin_oe);
		chk("f level", 8'h5A, o_port_f_pin);
		// Either range register nonzero hands all selects to the bus on the large variant; the small one follows only the I/O range
		for (int r = 8; r < 10; r++) begin
			wr(r[3:0], 8'h01);
			chk("f select oe", 8'hFF, o_port_f_pin_oe);
			chk("f select level", 8'h62, o_port_f_pin);
			chk("small f oe", (r == 8) ? 8'hD7 : 8'hFF, small_f_pin_oe);
			wr(r[3:0], 8'h00);
		end
		// Let the released select pins pass the synchroniser first
		repeat (3) @(posedge i_clk);
		rd(4'h1, 8'h7A);
		wr(4'h3, 8'h00);
		chk("f analog oe", 8'hC0, o_port_f_pin_oe);
		end_sim();
	end
endmodule
bind bus_shared_port bus_shared_port_props bus_shared_port_props_i (.i_clk,
	.i_reset, .i_address, .i_write_data, .i_write, .i_read, .o_read_data,
	.i_internal_execution, .i_bus_control_drive, .o_port_g_pin_oe,
	.o_port_f_pin_oe, .o_analog_pin_enable, .o_external_bus_disable,
	.o_bus_width_mode);
`default_nettype wire
